//--- controller_model.sv
/*
 * Model of the display controller: shift word, latch strobe and grayscale clock.
 * Assumes the strobe and grayscale clock are sampled by the block's own clock.
 */
module controller_model (
    input  wire logic   clk_sys_in,
    output logic [192:0] shift_word_out,
    output logic         latch_strobe_out,
    output logic         gray_count_clock_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        shift_word_out       = 193'h0;
        latch_strobe_out     = 1'b0;
        gray_count_clock_out = 1'b0;
    end

    // Word held well past detection, then scrambled like a shifting register
    task automatic write_word(input logic [192:0] w);
        @(posedge clk_sys_in) #2;
        shift_word_out = w;
        repeat (2) @(posedge clk_sys_in);
        #2 latch_strobe_out = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #2 latch_strobe_out = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #2 shift_word_out = ~w;
    endtask

    // Grayscale clock at 200 ns, idle low between bursts
    task automatic gs_pulses(input int n);
        #7;
        repeat (n) begin
            #100 gray_count_clock_out = 1'b1;
            #100 gray_count_clock_out = 1'b0;
        end
    endtask
endmodule // controller_model

//--- led_gray_and_control_latches.sv
/*
 * Latch stage of a 16-channel LED driver: first and second grayscale and control latches,
 * grayscale period counter, blanking, display repeat, timing reset and detection timing.
 * Assumes the common shift word comes from logic on clk_sys_in and is stable around each
 * strobe edge; the strobe and grayscale clock are pins and are synchronised here.
 */
module led_gray_and_control_latches
    import led_latch_pkg::*;
(
    input  wire logic                   clk_sys_in,
    input  wire logic                   srst_in,
    input  wire logic [SHIFT_WIDTH-1:0] shift_word_in,
    input  wire logic                   latch_strobe_in,
    input  wire logic                   gray_count_clock_in,
    output logic [GS_WIDTH-1:0]         channel_gray_level_out,
    output logic [CTRL2_WIDTH-1:0]      control_second_out,
    output logic [BC_WIDTH-1:0]         global_brightness_out,
    output logic [CHANNELS-1:0]         channel_on_out,
    output logic [11:0]                 gray_count_out,
    output logic                        outputs_blank_out,
    output logic                        auto_repeat_en_out,
    output logic                        timing_reset_en_out,
    output logic                        spread_pwm_en_out,
    output logic [1:0]                  open_threshold_sel_out,
    output logic [1:0]                  short_threshold_sel_out,
    output logic [1:0]                  detect_latch_time_sel_out,
    output logic                        invisible_detect_en_out,
    output logic                        invisible_detect_repeat_out,
    output logic [2:0]                  power_save_sel_out,
    output logic                        detect_latch_out
);
    logic                   strobe_rise;
    logic                   gs_rise;
    logic                   gray_write;
    logic                   ctrl_write;
    logic                   gs_copy;
    logic                   bc_copy;
    logic                   period_end;
    logic                   one_shot_detect;
    logic [11:0]            det_target;

    logic [GS_WIDTH-1:0]    gray_level_first_latch_reg;
    logic [GS_WIDTH-1:0]    gray_level_first_latch_next;
    logic [GS_WIDTH-1:0]    gray_second_reg;
    logic [GS_WIDTH-1:0]    gray_second_next;
    logic [CTRL1_WIDTH-1:0] control_first_latch_reg;
    logic [CTRL1_WIDTH-1:0] control_first_latch_next;
    logic [CTRL2_WIDTH-1:0] control_second_reg;
    logic [CTRL2_WIDTH-1:0] control_second_next;
    pwm_state_t             pwm_state_reg;
    pwm_state_t             pwm_state_next;
    logic [11:0]            count_reg;
    logic [11:0]            count_next;
    logic [CHANNELS-1:0]    channel_on_reg;
    logic [CHANNELS-1:0]    channel_on_next;
    logic                   gs_pend_reg;
    logic                   gs_pend_next;
    logic                   fresh_reg;
    logic                   fresh_next;
    logic                   detect_reg;
    logic                   detect_next;

    pin_edge_sync u_strobe_sync (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .pin_in     (latch_strobe_in),
        .rise_out   (strobe_rise)
    );

    pin_edge_sync u_gray_count_clock_sync (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .pin_in     (gray_count_clock_in),
        .rise_out   (gs_rise)
    );

    // Latch selection by the top bit alone
    assign gray_write = strobe_rise & ~shift_word_in[SEL_BIT];
    assign ctrl_write = strobe_rise &  shift_word_in[SEL_BIT];
    assign period_end = gs_rise && (pwm_state_reg == PWM_RUN) && (count_reg == PERIOD_LAST);

    // Latch group
    always_comb begin
        gray_level_first_latch_next = gray_level_first_latch_reg;
        control_first_latch_next    = control_first_latch_reg;
        if (gray_write) begin
            gray_level_first_latch_next = shift_word_in[GS_WIDTH-1:0];
        end
        if (ctrl_write) begin
            control_first_latch_next = shift_word_in[CTRL1_WIDTH-1:0];
        end
        // Copy on blank, timing reset strobe, or period end; grayscale copies at period end only with repeat
        gs_copy = control_first_latch_next[BLANK_BIT]
                  || (gray_write && control_first_latch_reg[TIMING_RESET_EN_BIT])
                  || (period_end && control_first_latch_reg[REPEAT_BIT]);
        bc_copy = control_first_latch_next[BLANK_BIT]
                  || (gray_write && control_first_latch_reg[TIMING_RESET_EN_BIT])
                  || period_end;
        gray_second_next    = gs_copy ? gray_level_first_latch_next : gray_second_reg;
        control_second_next = bc_copy ? control_first_latch_next[CTRL2_WIDTH-1:0]
                                      : control_second_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            gray_level_first_latch_reg <= '0;
            gray_second_reg            <= '0;
            control_second_reg         <= '0;
            control_first_latch_reg    <= '0;
            // Blank on and power save all ones after reset
            control_first_latch_reg[BLANK_BIT]            <= BLANK_RST;
            control_first_latch_reg[PSAVE_LSB+2:PSAVE_LSB] <= PSAVE_RST;
        end else begin
            gray_level_first_latch_reg <= gray_level_first_latch_next;
            gray_second_reg            <= gray_second_next;
            control_first_latch_reg    <= control_first_latch_next;
            control_second_reg         <= control_second_next;
        end
    end

    // Display timing group
    always_comb begin
        pwm_state_next = pwm_state_reg;
        count_next     = count_reg;
        if (control_first_latch_next[BLANK_BIT]) begin
            pwm_state_next = PWM_STOP;
            count_next     = '0;
        end else if (gray_write && control_first_latch_reg[TIMING_RESET_EN_BIT]) begin
            pwm_state_next = PWM_ARMED;
            count_next     = '0;
        end else begin
            case (pwm_state_reg)
                PWM_STOP: begin
                    if (control_first_latch_reg[BLANK_BIT]) begin
                        pwm_state_next = PWM_ARMED;
                    end
                end
                PWM_ARMED: begin
                    if (gs_rise) begin
                        pwm_state_next = PWM_RUN;
                        count_next     = COUNT_ONE;
                    end
                end
                PWM_RUN: begin
                    if (period_end) begin
                        count_next = '0;
                        if (!control_first_latch_reg[REPEAT_BIT]) begin
                            pwm_state_next = PWM_STOP;
                        end
                    end else if (gs_rise) begin
                        count_next = count_reg + COUNT_ONE;
                    end
                end
                default: begin
                    pwm_state_next = PWM_STOP;
                    count_next     = '0;
                end
            endcase
        end
    end

    // Conventional PWM per channel from the second latch
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            // Count zero after a repeat wrap is a gap, so a zero level stays dark
            assign channel_on_next[ch] = (pwm_state_reg == PWM_RUN) && (count_reg != '0)
                && (count_reg <= gray_second_reg[GS_FIELD*ch +: GS_FIELD]);
        end
    endgenerate

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pwm_state_reg  <= PWM_STOP;
            count_reg      <= '0;
            channel_on_reg <= '0;
        end else begin
            pwm_state_reg  <= pwm_state_next;
            count_reg      <= count_next;
            channel_on_reg <= channel_on_next;
        end
    end

    // Detection timing group
    always_comb begin
        case (control_first_latch_reg[LATTIME_LSB+1:LATTIME_LSB])
            2'h0:    det_target = DET_TIME_17;
            2'h1:    det_target = DET_TIME_33;
            2'h2:    det_target = DET_TIME_65;
            default: det_target = '0;
        endcase
        one_shot_detect = control_first_latch_reg[REPEAT_BIT]
                          && !control_first_latch_reg[INVISIBLE_DETECT_REPEAT_BIT];
        detect_next = gs_rise && (pwm_state_next == PWM_RUN) && (det_target != '0)
                      && (count_next == det_target) && (!one_shot_detect || fresh_reg);
        gs_pend_next = gs_copy ? 1'h0 : (gs_pend_reg | gray_write);
        fresh_next   = detect_next ? 1'h0 : fresh_reg;
        if (gs_copy && (gs_pend_reg || gray_write)) begin
            fresh_next = 1'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            gs_pend_reg <= 1'h0;
            fresh_reg   <= 1'h0;
            detect_reg  <= 1'h0;
        end else begin
            gs_pend_reg <= gs_pend_next;
            fresh_reg   <= fresh_next;
            detect_reg  <= detect_next;
        end
    end

    // Outputs from flops
    assign channel_gray_level_out      = gray_second_reg;
    assign control_second_out          = control_second_reg;
    assign global_brightness_out       = control_second_reg[BC_LSB +: BC_WIDTH];
    assign channel_on_out              = channel_on_reg;
    assign gray_count_out              = count_reg;
    assign outputs_blank_out           = control_first_latch_reg[BLANK_BIT];
    assign auto_repeat_en_out          = control_first_latch_reg[REPEAT_BIT];
    assign timing_reset_en_out         = control_first_latch_reg[TIMING_RESET_EN_BIT];
    assign spread_pwm_en_out           = control_first_latch_reg[SPREAD_PWM_EN_BIT];
    assign open_threshold_sel_out      = control_first_latch_reg[OPEN_LSB +: 2];
    assign short_threshold_sel_out     = control_first_latch_reg[SHORT_LSB +: 2];
    assign detect_latch_time_sel_out   = control_first_latch_reg[LATTIME_LSB +: 2];
    assign invisible_detect_en_out     = control_first_latch_reg[IDMENA_BIT];
    assign invisible_detect_repeat_out = control_first_latch_reg[INVISIBLE_DETECT_REPEAT_BIT];
    assign power_save_sel_out          = control_first_latch_reg[PSAVE_LSB +: 3];
    assign detect_latch_out            = detect_reg;

    // Checks
    sequence gray_write_s;
        gray_write;
    endsequence

    sequence ctrl_write_s;
        ctrl_write;
    endsequence

    gray_load_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        gray_write_s |=> gray_level_first_latch_reg == $past(shift_word_in[GS_WIDTH-1:0]))
        else $error("grayscale first latch not loaded");

    ctrl_load_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        ctrl_write_s |=> control_first_latch_reg == $past(shift_word_in[CTRL1_WIDTH-1:0]))
        else $error("control first latch not loaded");

    blank_copy_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        outputs_blank_out |-> gray_second_reg == gray_level_first_latch_reg
                              && control_second_reg == control_first_latch_reg[CTRL2_WIDTH-1:0])
        else $error("second latches differ while blanked");

    blank_off_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        outputs_blank_out ##1 outputs_blank_out |-> channel_on_out == '0 && gray_count_out == '0)
        else $error("outputs active while blanked");

    timing_reset_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        gray_write_s ##0 timing_reset_en_out ##0 !ctrl_write
        |=> gray_count_out == '0 && pwm_state_reg != PWM_RUN ##1 channel_on_out == '0)
        else $error("timing reset strobe did not clear counter");

    no_reset_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        gray_write && !timing_reset_en_out && !outputs_blank_out && !gs_rise
        |=> $stable(gray_count_out))
        else $error("strobe disturbed counter with timing reset off");

    resume_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        pwm_state_reg == PWM_ARMED && gs_rise && !strobe_rise
        |=> pwm_state_reg == PWM_RUN && gray_count_out == COUNT_ONE)
        else $error("PWM did not restart on grayscale clock");

    period_wrap_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        period_end && !strobe_rise
        |=> gray_count_out == '0 && (pwm_state_reg == PWM_RUN) == $past(auto_repeat_en_out))
        else $error("period end handled wrongly");

    detect_time_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        detect_latch_out |-> gray_count_out == $past(det_target) && $past(gs_rise))
        else $error("detection latched at wrong grayscale clock");

    reset_value_a: assert property (@(posedge clk_sys_in)
        srst_in |=> outputs_blank_out && power_save_sel_out == PSAVE_RST
                    && pwm_state_reg == PWM_STOP)
        else $error("reset values wrong");

endmodule // led_gray_and_control_latches

//--- led_gray_and_control_latches_test.sv
/*
 * Self-checking bench for the latch stage, driven through the controller model.
 * Assumes the design's assertions sit in its own files; expectations queue to a watcher.
 */
module led_gray_and_control_latches_test
    import led_latch_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clk_sys_in = 1'b0;
    logic                   srst_in = 1'b1;
    logic [SHIFT_WIDTH-1:0] shift_word;
    logic                   strobe;
    logic                   gray_count_clock;
    logic [GS_WIDTH-1:0]    gray;
    logic [CTRL2_WIDTH-1:0] ctl2;
    logic [BC_WIDTH-1:0]    bc;
    logic [CHANNELS-1:0]    chon;
    logic [11:0]            count;
    logic                   blank, rpt, tmg, esp, idmen, invisible_detect_repeat, det;
    logic [1:0]             opn, sht, lat;
    logic [2:0]             psave;
    string                  qn[$];
    logic [191:0]           qv[$];
    event                   chk_ev;
    int                     n_det = 0;
    int                     n_fail = 0;
    int                     checks_done = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    controller_model u_controller_model (
        .clk_sys_in          (clk_sys_in),
        .shift_word_out      (shift_word),
        .latch_strobe_out    (strobe),
        .gray_count_clock_out(gray_count_clock)
    );

    led_gray_and_control_latches u_led_gray_and_control_latches (
        .clk_sys_in                 (clk_sys_in),
        .srst_in                    (srst_in),
        .shift_word_in              (shift_word),
        .latch_strobe_in            (strobe),
        .gray_count_clock_in        (gray_count_clock),
        .channel_gray_level_out     (gray),
        .control_second_out         (ctl2),
        .global_brightness_out      (bc),
        .channel_on_out             (chon),
        .gray_count_out             (count),
        .outputs_blank_out          (blank),
        .auto_repeat_en_out         (rpt),
        .timing_reset_en_out        (tmg),
        .spread_pwm_en_out          (esp),
        .open_threshold_sel_out     (opn),
        .short_threshold_sel_out    (sht),
        .detect_latch_time_sel_out  (lat),
        .invisible_detect_en_out    (idmen),
        .invisible_detect_repeat_out(invisible_detect_repeat),
        .power_save_sel_out         (psave),
        .detect_latch_out           (det)
    );

    task automatic check(input string nm, input logic [191:0] seen, input logic [191:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic note(input string nm, input logic [191:0] v);
        qn.push_back(nm);
        qv.push_back(v);
        ->chk_ev;
        #1;
    endtask

    // Watcher takes the oldest note and compares it with the named output
    always @(chk_ev) begin
        string        nm;
        logic [191:0] ev;
        logic [191:0] s;
        nm = qn.pop_front();
        ev = qv.pop_front();
        case (nm)
            "blank":  s = 192'(blank);
            "rpt":    s = 192'(rpt);
            "tmg":    s = 192'(tmg);
            "esp":    s = 192'(esp);
            "open":   s = 192'(opn);
            "short":  s = 192'(sht);
            "lat":    s = 192'(lat);
            "idmen":  s = 192'(idmen);
            "invisible_detect_repeat": s = 192'(invisible_detect_repeat);
            "psave":  s = 192'(psave);
            "bc":     s = 192'(bc);
            "ctl2":   s = 192'(ctl2);
            "gray":   s = gray;
            "count":  s = 192'(count);
            "det":    s = 192'(n_det);
            default:  s = 192'(chon);
        endcase
        check(nm, s, ev);
    end

    // Counts detection strobes in mid-cycle, away from the launching edge
    always @(negedge clk_sys_in) begin
        if (det === 1'b1) begin
            n_det++;
        end
    end

    function automatic logic [191:0] rnd192();
        logic [191:0] r;
        for (int i = 0; i < 6; i++) r[i*32 +: 32] = $urandom();
        return r;
    endfunction

    function automatic logic [192:0] ctl(input logic bl, input logic rp, input logic tr,
                                         input logic [1:0] k);
        logic [192:0] w;
        w = {1'b1, rnd192()};
        w[BLANK_BIT]  = bl;
        w[REPEAT_BIT] = rp;
        w[TIMING_RESET_EN_BIT] = tr;
        w[SPREAD_PWM_EN_BIT]  = k[0];
        w[OPEN_LSB +: 2]    = k;
        w[SHORT_LSB +: 2]   = ~k;
        w[LATTIME_LSB +: 2] = k;
        w[PSAVE_LSB +: 3]   = {k[1], k};
        return w;
    endfunction

    function automatic logic [15:0] on_exp(input logic [191:0] g, input int c);
        logic [15:0] o;
        for (int n = 0; n < CHANNELS; n++) o[n] = (int'(g[n*GS_FIELD +: GS_FIELD]) >= c);
        return o;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_500_000;
        n_fail++;
        complete_run();
    end

    initial begin
        logic [192:0] w, w5, w6;
        logic [191:0] g, g5, g6;
        void'($urandom(32'hf030));
        repeat (20) @(posedge clk_sys_in);
        #2 srst_in = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        note("blank", 192'h1);
        note("psave", 192'h7);
        note("count", 192'h0);
        note("chon", 192'h0);
        $display("test reset done");
        // Control data written first, outputs kept blank
        for (int k = 0; k < 4; k++) begin
            w = ctl(1'b1, 1'b0, 1'b0, 2'(k));
            u_controller_model.write_word(w);
            note("esp", 192'(w[SPREAD_PWM_EN_BIT]));
            note("open", 192'(w[OPEN_LSB +: 2]));
            note("short", 192'(w[SHORT_LSB +: 2]));
            note("lat", 192'(w[LATTIME_LSB +: 2]));
            note("idmen", 192'(w[IDMENA_BIT]));
            note("invisible_detect_repeat", 192'(w[INVISIBLE_DETECT_REPEAT_BIT]));
            note("psave", 192'(w[PSAVE_LSB +: 3]));
            note("ctl2", 192'(w[118:0]));
            note("bc", 192'(w[118:112]));
            note("gray", 192'h0);
        end
        $display("test control fields done");
        g = rnd192();
        for (int n = 0; n < 8; n++) g[n*GS_FIELD +: GS_FIELD] = 12'(n + 6);
        u_controller_model.write_word({1'b0, g});
        note("gray", g);
        $display("test gray while blank done");
        u_controller_model.write_word(ctl(1'b0, 1'b0, 1'b0, 2'h1));
        note("blank", 192'h0);
        u_controller_model.write_word({1'b0, rnd192()});
        note("gray", g);
        u_controller_model.gs_pulses(10);
        repeat (4) @(posedge clk_sys_in);
        note("count", 192'd10);
        note("chon", 192'(on_exp(g, 10)));
        $display("test single period done");
        w5 = ctl(1'b0, 1'b0, 1'b1, 2'h2);
        u_controller_model.write_word(w5);
        note("tmg", 192'h1);
        g5 = rnd192();
        u_controller_model.write_word({1'b0, g5});
        note("gray", g5);
        note("count", 192'h0);
        note("ctl2", 192'(w5[118:0]));
        u_controller_model.gs_pulses(1);
        repeat (4) @(posedge clk_sys_in);
        note("count", 192'h1);
        $display("test timing reset done");
        // Detection at the 17th clock, once per new grayscale data
        w6 = ctl(1'b0, 1'b1, 1'b0, 2'h0);
        w6[INVISIBLE_DETECT_REPEAT_BIT] = 1'b0;
        u_controller_model.write_word(w6);
        note("rpt", 192'h1);
        g6 = rnd192();
        u_controller_model.write_word({1'b0, g6});
        note("gray", g5);
        note("ctl2", 192'(w5[118:0]));
        u_controller_model.gs_pulses(4095);
        repeat (4) @(posedge clk_sys_in);
        note("count", 192'h0);
        note("det", 192'h1);
        note("gray", g6);
        note("ctl2", 192'(w6[118:0]));
        note("bc", 192'(w6[118:112]));
        u_controller_model.gs_pulses(3);
        repeat (4) @(posedge clk_sys_in);
        note("count", 192'h3);
        note("chon", 192'(on_exp(g6, 3)));
        note("det", 192'h1);
        $display("test auto repeat done");
        complete_run();
    end
endmodule // led_gray_and_control_latches_test

//--- led_latch_pkg.sv
/*
 * Constants shared by the grayscale and control latch stage of a 16-channel LED driver.
 * Assumes nothing beyond a SystemVerilog compiler; bit positions are those of the shift word.
 */
package led_latch_pkg;

    localparam int          SHIFT_WIDTH  = 193;
    localparam int          SEL_BIT      = 192;
    localparam int          GS_WIDTH     = 192;
    localparam int          CTRL1_WIDTH  = 137;
    localparam int          CTRL2_WIDTH  = 119;
    localparam int          CHANNELS     = 16;
    localparam int          GS_FIELD     = 12;

    localparam int          BC_LSB       = 112;
    localparam int          BC_WIDTH     = 7;
    localparam int          BLANK_BIT    = 119;
    localparam int          REPEAT_BIT   = 120;
    localparam int          TIMING_RESET_EN_BIT   = 121;
    localparam int          SPREAD_PWM_EN_BIT    = 122;
    localparam int          OPEN_LSB     = 123;
    localparam int          SHORT_LSB    = 125;
    localparam int          LATTIME_LSB  = 127;
    localparam int          IDMENA_BIT   = 129;
    localparam int          INVISIBLE_DETECT_REPEAT_BIT   = 130;
    localparam int          PSAVE_LSB    = 134;

    localparam logic        BLANK_RST    = 1'h1;
    localparam logic [2:0]  PSAVE_RST    = 3'h7;

    localparam logic [11:0] PERIOD_LAST  = 12'hfff;
    localparam logic [11:0] COUNT_ONE    = 12'h001;
    localparam logic [11:0] DET_TIME_17  = 12'h011;
    localparam logic [11:0] DET_TIME_33  = 12'h021;
    localparam logic [11:0] DET_TIME_65  = 12'h041;

    typedef enum logic [1:0] {
        PWM_STOP  = 2'b00,
        PWM_ARMED = 2'b01,
        PWM_RUN   = 2'b10
    } pwm_state_t;

endpackage

//--- pin_edge_sync.sv
/*
 * Two-flop synchroniser with rising-edge detector for a pin from outside the clock domain.
 * Assumes the pin stays at each level for at least two system clock periods.
 */
module pin_edge_sync (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    input  wire logic pin_in,
    output logic      rise_out
);
    logic meta_reg;
    logic meta_next;
    logic stable_reg;
    logic stable_next;
    logic prev_reg;
    logic prev_next;

    always_comb begin
        meta_next   = pin_in;
        stable_next = meta_reg;
        prev_next   = stable_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta_reg   <= 1'h0;
            stable_reg <= 1'h0;
            prev_reg   <= 1'h0;
        end else begin
            meta_reg   <= meta_next;
            stable_reg <= stable_next;
            prev_reg   <= prev_next;
        end
    end

    // Edge seen only after the second flop
    assign rise_out = stable_reg & ~prev_reg;

endmodule // pin_edge_sync
